// [rtl/tic_consts.svh]
// register offsets, field positions, reset values and count limits of the interval counter
`ifndef TIC_CONSTS_SVH
`define TIC_CONSTS_SVH

// ==========================================================
// register offsets on the core's special function bus
`define TIC_OFS_FRAC        8'ha2
`define TIC_OFS_SEC         8'ha3
`define TIC_OFS_MIN         8'ha4
`define TIC_OFS_HOUR        8'ha5
`define TIC_OFS_TARGET      8'ha6
`define TIC_OFS_CTRL        8'ha7

// ==========================================================
// timer control register fields
`define TIC_CTRL_RUN_BIT    0
`define TIC_CTRL_IEN_BIT    1
`define TIC_CTRL_FLAG_BIT   2
`define TIC_CTRL_SPARE_BIT  3
`define TIC_CTRL_UNIT_LO    4
`define TIC_CTRL_UNIT_HI    5
`define TIC_CTRL_H24_BIT    6
`define TIC_CTRL_TOP_BIT    7

// ==========================================================
// reset values
`define TIC_RST_COUNT       8'h00
`define TIC_RST_TARGET      8'h00
`define TIC_RST_CTRL        8'h00

// ==========================================================
// last value of each time counter before it rolls over
`define TIC_MAX_FRAC        8'h7f
`define TIC_MAX_SEC         8'h3b
`define TIC_MAX_MIN         8'h3b
`define TIC_MAX_HOUR        8'h17

`endif

// [rtl/tic_pkg.sv]
// types shared by the interval counter design
package tic_pkg;

  // ==========================================================
  // unit that advances the interval counter
  typedef enum logic [1:0] {
    TIC_UNIT_FRAC,
    TIC_UNIT_SEC,
    TIC_UNIT_MIN,
    TIC_UNIT_HOUR
  } tic_unit_t;

  typedef logic [7:0] tic_byte_t;

endpackage : tic_pkg

// [rtl/tic_wrap_cnt.sv]
// one cascaded time counter stage with software load and rollover
`timescale 1ns/1ns
`include "tic_consts.svh"

module tic_wrap_cnt #(
  parameter logic [7:0] MAX_VAL = 8'h3b  // last value before rollover
) (
  input  wire logic              clk,       // core clock
  input  wire logic              nrst,      // async reset, active low
  input  wire logic              tick,      // advance by one this cycle
  input  wire logic              load_en,   // software write strobe
  input  wire tic_pkg::tic_byte_t load_val, // value written by software
  output tic_pkg::tic_byte_t     count_q,   // current count
  output logic                   wrap       // pulse: rolls over this cycle
);
  import tic_pkg::*;

  tic_byte_t count_d;

  // ==========================================================
  // next count: a write beats a tick so software never loses a preload
  always_comb begin
    count_d = count_q;
    if (load_en) begin
      count_d = load_val;
    end else if (tick) begin
      // values above the limit, written by software, also roll to zero
      count_d = (count_q >= MAX_VAL) ? `TIC_RST_COUNT : count_q + 8'h01;
    end
  end

  // rollover only counts when the tick is not overridden by a write
  assign wrap = tick && !load_en && (count_q >= MAX_VAL);

  // ==========================================================
  // count register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= `TIC_RST_COUNT;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : tic_wrap_cnt

// [rtl/tic_rtc.sv]
// time interval counter: real-time clock chain, interval timer and its registers
`timescale 1ns/1ns
`include "tic_consts.svh"

// Functional notes
// - interval count reaching target sets match flag, requests interrupt when enabled.
// - interval target accepts any value 0 to 255 in selected unit.
// - fraction counter steps each 1/128 s while running, 0..127, carries to seconds.
// - seconds counter counts 0..59 while running, carries into minutes.
// - minutes counter counts 0..59 while running, carries into hours.
// - hours counter counts 0..23 while running, then wraps to zero.
// - time counters may be preloaded; counting starts only once run bit is high.
// - two unit select bits pick fraction, second, minute or hour interval ticks.
// - 0xd0 selects 24-hour seconds unit stopped; 0xd3 starts with interval counting.
module tic_rtc (
  input  wire logic               clk,          // core clock, 100 MHz
  input  wire logic               nrst,         // async reset, active low
  input  wire logic               tick_128,     // 1/128 s enable pulse, same clock
  input  wire tic_pkg::tic_byte_t sfr_addr,     // register address from the core
  input  wire logic               sfr_wr,       // write strobe, one cycle
  input  wire logic               sfr_rd,       // read strobe, one cycle
  input  wire tic_pkg::tic_byte_t sfr_wdata,    // write data
  input  wire logic               irq_enable,   // interrupt enable from the core
  output tic_pkg::tic_byte_t      sfr_rdata,    // read data, one cycle after sfr_rd
  output logic                    sfr_hit,      // address belongs to this block
  output logic                    interval_match_flag, // sticky match flag
  output logic                    tic_irq       // interrupt request level
);
  import tic_pkg::*;

  // ==========================================================
  // address decode, shared by write and read paths
  function automatic logic is_reg(input tic_byte_t addr, input tic_byte_t ofs);
    is_reg = (addr == ofs);
  endfunction : is_reg

  logic wr_frac;
  logic wr_sec;
  logic wr_min;
  logic wr_hour;
  logic wr_target;
  logic wr_ctrl;

  // write strobes per register
  assign wr_frac   = sfr_wr && is_reg(sfr_addr, `TIC_OFS_FRAC);
  assign wr_sec    = sfr_wr && is_reg(sfr_addr, `TIC_OFS_SEC);
  assign wr_min    = sfr_wr && is_reg(sfr_addr, `TIC_OFS_MIN);
  assign wr_hour   = sfr_wr && is_reg(sfr_addr, `TIC_OFS_HOUR);
  assign wr_target = sfr_wr && is_reg(sfr_addr, `TIC_OFS_TARGET);
  assign wr_ctrl   = sfr_wr && is_reg(sfr_addr, `TIC_OFS_CTRL);

  // hit lets the core merge read data from several peripherals
  assign sfr_hit = is_reg(sfr_addr, `TIC_OFS_FRAC)
                || is_reg(sfr_addr, `TIC_OFS_SEC)
                || is_reg(sfr_addr, `TIC_OFS_MIN)
                || is_reg(sfr_addr, `TIC_OFS_HOUR)
                || is_reg(sfr_addr, `TIC_OFS_TARGET)
                || is_reg(sfr_addr, `TIC_OFS_CTRL);

  // ==========================================================
  // timer control register
  logic      run_q;
  logic      run_d;
  logic      ien_q;
  logic      ien_d;
  logic      flag_q;
  logic      flag_d;
  logic      spare_q;
  logic      spare_d;
  logic      h24_q;
  logic      h24_d;
  logic      top_q;
  logic      top_d;
  tic_unit_t unit_q;
  tic_unit_t unit_d;
  logic      match;

  // control fields; a new match wins over a software clear of the flag
  always_comb begin
    run_d   = run_q;
    ien_d   = ien_q;
    spare_d = spare_q;
    h24_d   = h24_q;
    top_d   = top_q;
    unit_d  = unit_q;
    flag_d  = flag_q;
    if (wr_ctrl) begin
      run_d   = sfr_wdata[`TIC_CTRL_RUN_BIT];
      ien_d   = sfr_wdata[`TIC_CTRL_IEN_BIT];
      spare_d = sfr_wdata[`TIC_CTRL_SPARE_BIT];
      h24_d   = sfr_wdata[`TIC_CTRL_H24_BIT];
      top_d   = sfr_wdata[`TIC_CTRL_TOP_BIT];
      unit_d  = tic_unit_t'(sfr_wdata[`TIC_CTRL_UNIT_HI:`TIC_CTRL_UNIT_LO]);
      flag_d  = sfr_wdata[`TIC_CTRL_FLAG_BIT];
    end
    if (match) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q   <= 1'(`TIC_RST_CTRL >> `TIC_CTRL_RUN_BIT);
      ien_q   <= 1'b0;
      flag_q  <= 1'b0;
      spare_q <= 1'b0;
      h24_q   <= 1'b0;
      top_q   <= 1'b0;
      unit_q  <= TIC_UNIT_FRAC;
    end else begin
      run_q   <= run_d;
      ien_q   <= ien_d;
      flag_q  <= flag_d;
      spare_q <= spare_d;
      h24_q   <= h24_d;
      top_q   <= top_d;
      unit_q  <= unit_d;
    end
  end

  // ==========================================================
  // time counter chain
  tic_byte_t frac_q;
  tic_byte_t sec_q;
  tic_byte_t min_q;
  tic_byte_t hour_q;
  logic      frac_tick;
  logic      frac_wrap;
  logic      sec_wrap;
  logic      min_wrap;
  logic      hour_wrap;

  // the external tick is already one cycle wide on this clock, so no
  // synchroniser; nothing moves while the run bit is low
  assign frac_tick = tick_128 && run_q;

  tic_wrap_cnt #(
    .MAX_VAL (`TIC_MAX_FRAC)
  ) u_frac (
    .clk      (clk),
    .nrst     (nrst),
    .tick     (frac_tick),
    .load_en  (wr_frac),
    .load_val (sfr_wdata),
    .count_q  (frac_q),
    .wrap     (frac_wrap)
  );

  tic_wrap_cnt #(
    .MAX_VAL (`TIC_MAX_SEC)
  ) u_sec (
    .clk      (clk),
    .nrst     (nrst),
    .tick     (frac_wrap),
    .load_en  (wr_sec),
    .load_val (sfr_wdata),
    .count_q  (sec_q),
    .wrap     (sec_wrap)
  );

  tic_wrap_cnt #(
    .MAX_VAL (`TIC_MAX_MIN)
  ) u_min (
    .clk      (clk),
    .nrst     (nrst),
    .tick     (sec_wrap),
    .load_en  (wr_min),
    .load_val (sfr_wdata),
    .count_q  (min_q),
    .wrap     (min_wrap)
  );

  // hours always run the 24-hour range; the mode bit is only stored
  tic_wrap_cnt #(
    .MAX_VAL (`TIC_MAX_HOUR)
  ) u_hour (
    .clk      (clk),
    .nrst     (nrst),
    .tick     (min_wrap),
    .load_en  (wr_hour),
    .load_val (sfr_wdata),
    .count_q  (hour_q),
    .wrap     (hour_wrap)
  );

  // ==========================================================
  // interval target register
  tic_byte_t target_q;
  tic_byte_t target_d;

  // all 256 codes are legal, so the value is stored as written
  always_comb begin
    target_d = target_q;
    if (wr_target) begin
      target_d = sfr_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      target_q <= `TIC_RST_TARGET;
    end else begin
      target_q <= target_d;
    end
  end

  // ==========================================================
  // interval counter
  tic_byte_t ival_q;
  tic_byte_t ival_d;
  tic_byte_t ival_inc;
  logic      ien_prev_q;
  logic      ien_prev_d;
  logic      unit_tick;
  logic      ien_rise;

  // select the unit tick for the interval counter
  always_comb begin
    unique case (unit_q)
      TIC_UNIT_FRAC: unit_tick = frac_tick;
      TIC_UNIT_SEC:  unit_tick = frac_wrap;
      TIC_UNIT_MIN:  unit_tick = sec_wrap;
      TIC_UNIT_HOUR: unit_tick = min_wrap;
    endcase
  end

  assign ien_rise = ien_q && !ien_prev_q;
  assign ival_inc = ival_q + 8'h01;
  // target zero matches after 256 units, since the 8-bit count wraps to zero;
  // longer intervals are left to software chaining matches
  assign match = ien_q && !ien_rise && unit_tick && (ival_inc == target_q);

  // clear on enable and after each match so matches repeat every target units
  always_comb begin
    ien_prev_d = ien_q;
    ival_d     = ival_q;
    if (!ien_q || ien_rise) begin
      ival_d = `TIC_RST_COUNT;
    end else if (match) begin
      ival_d = `TIC_RST_COUNT;
    end else if (unit_tick) begin
      ival_d = ival_inc;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ival_q     <= `TIC_RST_COUNT;
      ien_prev_q <= 1'b0;
    end else begin
      ival_q     <= ival_d;
      ien_prev_q <= ien_prev_d;
    end
  end

  // ==========================================================
  // read data and status outputs
  tic_byte_t rdata_d;
  tic_byte_t ctrl_view;

  assign ctrl_view = {top_q, h24_q, unit_q, spare_q, flag_q, ien_q, run_q};

  // registered read data keeps the core's bus free of comparator paths
  always_comb begin
    rdata_d = sfr_rdata;
    if (sfr_rd) begin
      rdata_d = 8'h00;
      if (is_reg(sfr_addr, `TIC_OFS_FRAC)) begin
        rdata_d = frac_q;
      end
      if (is_reg(sfr_addr, `TIC_OFS_SEC)) begin
        rdata_d = sec_q;
      end
      if (is_reg(sfr_addr, `TIC_OFS_MIN)) begin
        rdata_d = min_q;
      end
      if (is_reg(sfr_addr, `TIC_OFS_HOUR)) begin
        rdata_d = hour_q;
      end
      if (is_reg(sfr_addr, `TIC_OFS_TARGET)) begin
        rdata_d = target_q;
      end
      if (is_reg(sfr_addr, `TIC_OFS_CTRL)) begin
        rdata_d = ctrl_view;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= rdata_d;
    end
  end

  // the hour rollover has no further stage; it is not used beyond this point
  logic unused_hour_wrap;
  assign unused_hour_wrap = hour_wrap;

  assign interval_match_flag = flag_q;
  assign tic_irq             = flag_q && irq_enable;

endmodule : tic_rtc

// [tb/tic_rtc_asserts.sv]
// concurrent checks on the ports of the interval counter
`timescale 1ns/1ns

module tic_rtc_asserts (
  input wire logic               clk,                 // core clock
  input wire logic               nrst,                // async reset, active low
  input wire logic               tick_128,            // 1/128 s enable
  input wire tic_pkg::tic_byte_t sfr_addr,            // register address
  input wire logic               sfr_wr,              // write strobe
  input wire logic               sfr_rd,              // read strobe
  input wire tic_pkg::tic_byte_t sfr_wdata,           // write data
  input wire logic               irq_enable,          // interrupt enable
  input wire tic_pkg::tic_byte_t sfr_rdata,           // read data
  input wire logic               sfr_hit,             // address decode
  input wire logic               interval_match_flag, // sticky flag
  input wire logic               tic_irq              // interrupt request
);
  import tic_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // interrupt and flag
  irq_level_a: assert property (tic_irq == (interval_match_flag && irq_enable))
    else $error("irq level differs from flag and enable");
  flag_cause_a: assert property ($rose(interval_match_flag) |-> $past(tick_128) || $past(sfr_wr))
    else $error("flag rose without a tick");
  flag_sticky_a: assert property (interval_match_flag && !sfr_wr |=> interval_match_flag)
    else $error("flag dropped without a write");
  flag_clear_a: assert property ($fell(interval_match_flag) |-> $past(sfr_wr) && $past(sfr_addr) == 8'ha7)
    else $error("flag cleared by a foreign write");

  // ==========================================================
  // register bus; reads must not drift, so software sees one stable byte
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  hit_decode_a: assert property (sfr_hit == (sfr_addr inside {[8'ha2:8'ha7]}))
    else $error("address decode wrong");
  unmapped_zero_a: assert property (sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  target_back_a: assert property (sfr_wr && sfr_addr == 8'ha6 ##1 !sfr_wr ##1
    sfr_rd && sfr_addr == 8'ha6 |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("target read back wrong");

  c_flag: cover property ($rose(interval_match_flag));
  c_irq: cover property ($rose(tic_irq));
  c_unmap: cover property (sfr_rd && !sfr_hit);
endmodule : tic_rtc_asserts

// [tb/tb.sv]
// self-checking bench for the interval counter with a byte-array model
`timescale 1ns/1ns

module tb;
  import tic_pkg::*;
  logic clk, nrst, tick_128, sfr_wr, sfr_rd, irq_enable, sfr_hit, flag, tic_irq;
  tic_byte_t sfr_addr, sfr_wdata, sfr_rdata, t;
  logic [7:0] m[6];   // model: frac, sec, min, hour, target, ctrl
  logic [7:0] ic;     // model interval count
  int lim[4] = '{127, 59, 59, 23};
  int failures = 0;
  int samples_checked = 0;

  tic_rtc uut (.clk(clk), .nrst(nrst), .tick_128(tick_128), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .irq_enable(irq_enable),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .interval_match_flag(flag), .tic_irq(tic_irq));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task end_sim;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // bus tasks; the model follows every write
  task wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'ha7 && !(m[5][1] && d[1])) ic = 8'h00;
    if (a > 8'ha1 && a < 8'ha8) m[a - 8'ha2] = d;
    @(posedge clk) #1;
    {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(posedge clk) #1 sfr_wr = 0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #1;
    {sfr_addr, sfr_rd} = {a, 1'b1};
    @(posedge clk) #1 sfr_rd = 0;
    chk("rdata", sfr_rdata, e);
  endtask : rd

  task rdall;
    for (int i = 0; i < 6; i++) rd(8'(8'ha2 + i), m[i]);
  endtask : rdall

  // one 1/128 s pulse: counters cascade, then the interval unit
  task tk;
    logic [3:0] u;
    logic c;
    u = 4'h0;
    c = m[5][0];
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        u[i] = 1;
        c = m[i] >= lim[i];
        m[i] = c ? 8'h00 : m[i] + 8'h01;
      end
    end
    if (m[5][1] && u[m[5][5:4]]) begin
      if (ic + 8'h01 == m[4]) {m[5][2], ic} = {1'b1, 8'h00};
      else ic = ic + 8'h01;
    end
    @(posedge clk) #1;
    {tick_128, irq_enable} = {1'b1, 1'($urandom)};
    @(posedge clk) #1 tick_128 = 0;
    chk("flag", flag, m[5][2]);
    chk("irq", tic_irq, m[5][2] & irq_enable);
  endtask : tk

  initial begin
    {tick_128, sfr_addr, sfr_wr, sfr_rd, sfr_wdata, irq_enable} = '0;
    {nrst, ic} = '0;
    foreach (m[i]) m[i] = 8'h00;
    void'($urandom(32'h5277));
    repeat (2) @(posedge clk);
    #1 nrst = 1;
    // reset values, unmapped read, stopped clock ignores ticks
    rdall;
    rd(8'hb0, 8'h00);
    tk;
    rdall;
    $display("test reset done");
    // full cascade rollover from 22 and 23 hours
    for (int h = 22; h < 24; h++) begin
      wr(8'ha7, 8'h40);
      for (int j = 0; j < 3; j++) wr(8'(8'ha2 + j), 8'(lim[j]));
      wr(8'ha5, 8'(h));
      wr(8'ha7, 8'h41);
      tk;
      rdall;
    end
    $display("test rollover done");
    // random preload then a random run length
    wr(8'ha7, 8'h00);
    for (int j = 0; j < 4; j++) wr(8'(8'ha2 + j), 8'($urandom % (lim[j] + 1)));
    wr(8'ha7, 8'h01);
    repeat ($urandom % 300 + 1) tk;
    rdall;
    $display("test run done");
    // interval match in every unit, stop then start
    for (int u = 0; u < 4; u++) begin
      wr(8'ha7, 8'(8'hc0 | u << 4));
      t = 8'($urandom % 3 + 1);
      wr(8'ha6, t);
      rd(8'ha6, t);
      wr(8'ha7, 8'(8'hc3 | u << 4));
      // lower stages parked at their limit so each pulse is one unit
      repeat (2 * t + 1) begin
        for (int j = 0; j < u; j++) wr(8'(8'ha2 + j), 8'(lim[j]));
        tk;
      end
      rdall;
      wr(8'ha7, 8'(8'hc3 | u << 4));
      chk("flag clear", flag, 1'b0);
    end
    $display("test interval done");
    end_sim;
  end

  initial begin
    #200000;
    failures++;
    end_sim;
  end
endmodule : tb

bind tic_rtc tic_rtc_asserts u_chk (.clk(clk), .nrst(nrst), .tick_128(tick_128),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .irq_enable(irq_enable), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
  .interval_match_flag(interval_match_flag), .tic_irq(tic_irq));
